//--- core/tw_unit.sv
/*
 * Timer waveform output unit: 8-bit counter with normal, clear-on-match
 * and fast PWM counting, two compare channels driving two pins, and an
 * AHB-Lite register slave with zero wait states.
 * Assumes one clock, bus signals synchronous to it, pins asynchronous.
 */
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`include "tw_params.svh"
`default_nettype none
module tw_unit
    import tw_pkg::*;
#(
    parameter int DIV_W = 10
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_pin_a,
    output logic o_pin_a,
    output logic o_pin_a_oe,
    input wire logic i_pin_b,
    output logic o_pin_b,
    output logic o_pin_b_oe
);

    if (DIV_W < 10) begin : g_chk
        $error("DIV_W must hold a divide by 1024");
    end

    function automatic tw_cnt_e cnt_mode(input logic [2:0] wgm);
        case (wgm)
            `TW_WGM_CTC: cnt_mode = TW_CLEAR;
            `TW_WGM_FAST_MAX, `TW_WGM_FAST_TOP: cnt_mode = TW_FAST; // [R14]
            default: cnt_mode = TW_NORMAL; // [R25]
        endcase
    endfunction

    function automatic logic [DIV_W-1:0] div_last(input logic [2:0] sel);
        case (sel)
            3'h1: div_last = DIV_W'(`TW_DIV_1 - 1);
            3'h2: div_last = DIV_W'(`TW_DIV_8 - 1);
            3'h3: div_last = DIV_W'(`TW_DIV_32 - 1);
            3'h4: div_last = DIV_W'(`TW_DIV_64 - 1);
            3'h5: div_last = DIV_W'(`TW_DIV_128 - 1);
            3'h6: div_last = DIV_W'(`TW_DIV_256 - 1);
            default: div_last = DIV_W'(`TW_DIV_1024 - 1);
        endcase
    endfunction

    function automatic logic apply_act(input logic [1:0] act,
                                       input logic cur);
        case (act)
            TW_ACT_TOGGLE: apply_act = ~cur;
            TW_ACT_CLEAR: apply_act = 1'b0;
            TW_ACT_SET: apply_act = 1'b1;
            default: apply_act = cur;
        endcase
    endfunction

    // Bus slave state.
    tw_ap_s ap_q;
    tw_ap_s ap_d;
    logic [31:0] rdata_d;

    // Timer state.
    tw_ctrl_s ctrl_q;
    tw_ctrl_s ctrl_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] cmp_buf_q [2];
    logic [7:0] cmp_buf_d [2];
    logic [7:0] cmp_act_q [2];
    logic [7:0] cmp_act_d [2];
    logic [2:0] flags_q;
    logic [2:0] flags_d;
    logic [2:0] flags_set;
    logic [2:0] flags_clr;
    logic [1:0] port_out_q;
    logic [1:0] port_out_d;
    logic [1:0] dir_q;
    logic [1:0] dir_d;
    logic [1:0] wave_q;
    logic [1:0] wave_d;
    logic blk_q;
    logic blk_d;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic [1:0] pin_d;
    logic [1:0] oe_d;

    tw_cnt_e mode;
    logic tick;
    logic wrap;
    logic pwm;
    logic [7:0] top;
    logic [1:0] act_sel [2];
    logic [1:0] match;
    logic [1:0] force_w;
    logic [1:0] wr_cmp;
    logic wr_ctrl;
    logic wr_force;
    logic wr_count;
    logic wr_flags;
    logic wr_port;

    assign wr_ctrl = ap_q.wr && (ap_q.addr == `TW_OFF_CTRL);
    assign wr_force = ap_q.wr && (ap_q.addr == `TW_OFF_FORCE);
    assign wr_count = ap_q.wr && (ap_q.addr == `TW_OFF_COUNT);
    assign wr_cmp[0] = ap_q.wr && (ap_q.addr == `TW_OFF_CMPA);
    assign wr_cmp[1] = ap_q.wr && (ap_q.addr == `TW_OFF_CMPB);
    assign wr_flags = ap_q.wr && (ap_q.addr == `TW_OFF_FLAGS);
    assign wr_port = ap_q.wr && (ap_q.addr == `TW_OFF_PORT);
    assign act_sel[0] = ctrl_q.act_a;
    assign act_sel[1] = ctrl_q.act_b;

    // Read data is sampled in the address phase, so a read that directly
    // follows a write to the same register still returns the old value.
    always_comb begin
        ap_d.wr = i_hsel && i_htrans[1] && i_hready && i_hwrite;
        ap_d.rd = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
        ap_d.addr = i_haddr[7:0];
        rdata_d = 32'h0;
        if (ap_d.rd) begin
            case (ap_d.addr)
                `TW_OFF_CTRL: rdata_d = {21'h0, ctrl_q};
                `TW_OFF_COUNT: rdata_d = {24'h0, count_q};
                `TW_OFF_CMPA: rdata_d = {24'h0, cmp_buf_q[0]};
                `TW_OFF_CMPB: rdata_d = {24'h0, cmp_buf_q[1]};
                `TW_OFF_FLAGS: rdata_d = {29'h0, flags_q};
                `TW_OFF_PORT: begin
                    rdata_d = {24'h0, pin_sync_q, wave_q, dir_q, port_out_q};
                end
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ap_q <= '0;
            o_hrdata <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            ap_q <= ap_d;
            o_hrdata <= rdata_d;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    always_comb begin
        mode = cnt_mode(ctrl_q.wgm); // [R06]
        pwm = (mode == TW_FAST);
        tick = (ctrl_q.clk_sel != 3'h0) &&
               (div_q == div_last(ctrl_q.clk_sel)); // [R20][R21]
        div_d = (tick || ctrl_q.clk_sel == 3'h0) ? '0 : div_q + 1'b1;
        top = (ctrl_q.wgm == `TW_WGM_FAST_TOP) ? cmp_act_q[0] : `TW_CNT_MAX;
        ctrl_d = wr_ctrl ? tw_ctrl_s'(i_hwdata[10:0]) : ctrl_q;
        count_d = count_q;
        blk_d = blk_q;
        wrap = 1'b0;
        flags_set = 3'h0;
        if (tick) begin
            blk_d = 1'b0;
            case (mode)
                TW_CLEAR: begin
                    // [R10][R11]
                    if (count_q == cmp_act_q[0]) begin
                        count_d = `TW_CNT_BOTTOM;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                    flags_set[`TW_FLAG_OVF] = (count_q == `TW_CNT_MAX); // [R13]
                end
                TW_FAST: begin
                    if (count_q == top) begin
                        count_d = `TW_CNT_BOTTOM; // [R15]
                        wrap = 1'b1;
                        flags_set[`TW_FLAG_OVF] = 1'b1; // [R17]
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end
                default: begin
                    count_d = count_q + 8'h01; // [R07]
                    flags_set[`TW_FLAG_OVF] = (count_q == `TW_CNT_MAX); // [R08]
                end
            endcase
        end
        // A software count write wins over counting and hides the match
        // of the next tick, so a compare equal to the new count is quiet.
        if (wr_count) begin
            count_d = i_hwdata[7:0]; // [R09]
            blk_d = 1'b1;
        end
        wave_d = wave_q;
        for (int ch = 0; ch < 2; ch++) begin
            match[ch] = tick && !blk_q && (count_q == cmp_act_q[ch]);
            force_w[ch] = wr_force && i_hwdata[ch] && !pwm; // [R05]
            flags_set[`TW_FLAG_MA + ch] = match[ch]; // [R13][R22][R24]
            cmp_buf_d[ch] = cmp_buf_q[ch];
            cmp_act_d[ch] = cmp_act_q[ch];
            if (match[ch] || force_w[ch]) begin
                // [R04][R05][R12][R16][R19][R24]
                wave_d[ch] = apply_act(act_sel[ch], wave_q[ch]);
            end
            // The wrap action is applied after the match so that a
            // compare at MAX gives a steady level rather than a glitch.
            if (wrap && act_sel[ch] == TW_ACT_CLEAR) begin
                wave_d[ch] = 1'b1; // [R16][R18]
            end else if (wrap && act_sel[ch] == TW_ACT_SET) begin
                wave_d[ch] = 1'b0; // [R16][R18]
            end
            if (pwm && wrap) begin
                cmp_act_d[ch] = cmp_buf_q[ch]; // [R23]
            end
            if (wr_cmp[ch]) begin
                cmp_buf_d[ch] = i_hwdata[7:0];
                if (!pwm) begin
                    cmp_act_d[ch] = i_hwdata[7:0]; // [R11][R23]
                end
            end
            pin_d[ch] = (act_sel[ch] != TW_ACT_NONE) ? wave_q[ch]
                                                     : port_out_q[ch]; // [R01][R03]
            oe_d[ch] = dir_q[ch]; // [R02]
        end
        flags_clr = wr_flags ? i_hwdata[2:0] : 3'h0;
        flags_d = (flags_q & ~flags_clr) | flags_set; // [R22]
        port_out_d = port_out_q;
        dir_d = dir_q;
        if (wr_port) begin
            port_out_d = i_hwdata[`TW_PORT_OUT_LSB +: 2];
            dir_d = i_hwdata[`TW_PORT_DIR_LSB +: 2];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= `TW_CTRL_RST;
            count_q <= `TW_CNT_BOTTOM;
            cmp_buf_q[0] <= `TW_CMP_RST;
            cmp_buf_q[1] <= `TW_CMP_RST;
            cmp_act_q[0] <= `TW_CMP_RST;
            cmp_act_q[1] <= `TW_CMP_RST;
            flags_q <= `TW_FLAGS_RST;
            port_out_q <= `TW_PORT_RST;
            dir_q <= `TW_PORT_RST;
            wave_q <= `TW_PORT_RST;
            blk_q <= 1'b0;
            div_q <= '0;
            pin_meta_q <= 2'h0;
            pin_sync_q <= 2'h0;
            o_pin_a <= 1'b0;
            o_pin_b <= 1'b0;
            o_pin_a_oe <= 1'b0;
            o_pin_b_oe <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            cmp_buf_q <= cmp_buf_d;
            cmp_act_q <= cmp_act_d;
            flags_q <= flags_d;
            port_out_q <= port_out_d;
            dir_q <= dir_d;
            wave_q <= wave_d;
            blk_q <= blk_d;
            div_q <= div_d;
            pin_meta_q <= {i_pin_b, i_pin_a};
            pin_sync_q <= pin_meta_q;
            o_pin_a <= pin_d[0];
            o_pin_b <= pin_d[1];
            o_pin_a_oe <= oe_d[0];
            o_pin_b_oe <= oe_d[1];
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    pin_override_a: assert property ( // [R01][R03]
        (ctrl_q.act_a != 2'h0) |=> (o_pin_a == $past(wave_q[0])))
        else $error("pin a not driven from waveform state");

    pin_dir_a: assert property ( // [R02]
        $rose(dir_q[0]) |=> o_pin_a_oe ##1 o_pin_a_oe == $past(dir_q[0]))
        else $error("pin a enable does not follow direction");

    normal_wrap_a: assert property ( // [R07][R08]
        (tick && mode == TW_NORMAL && count_q == `TW_CNT_MAX && !wr_count)
        |=> (count_q == `TW_CNT_BOTTOM && flags_q[`TW_FLAG_OVF]))
        else $error("normal mode wrap or overflow wrong");

    ctc_clear_a: assert property ( // [R10]
        (tick && mode == TW_CLEAR && count_q == cmp_act_q[0] && !wr_count)
        |=> (count_q == `TW_CNT_BOTTOM))
        else $error("clear mode did not clear at compare");

    fast_top_a: assert property ( // [R15][R17]
        (tick && mode == TW_FAST && count_q == top && !wr_count)
        |=> (count_q == `TW_CNT_BOTTOM && flags_q[`TW_FLAG_OVF]))
        else $error("fast pwm top handling wrong");

    match_flag_a: assert property ( // [R22]
        (tick && !blk_q && count_q == cmp_act_q[0]) |=> flags_q[`TW_FLAG_MA])
        else $error("match flag a not set");

    zero_action_a: assert property ( // [R04]
        (ctrl_q.act_a == 2'h0) |=> $stable(wave_q[0]))
        else $error("action zero changed waveform a");

    force_toggle_a: assert property ( // [R05][R24]
        (wr_force && i_hwdata[0] && mode != TW_FAST && !match[0] &&
         ctrl_q.act_a == 2'h1 && !wr_flags && !flags_q[`TW_FLAG_MA])
        |=> (wave_q[0] != $past(wave_q[0]) && !flags_q[`TW_FLAG_MA]))
        else $error("force strobe misbehaved on channel a");

    buf_hold_a: assert property ( // [R23]
        (wr_cmp[0] && mode == TW_FAST && !wrap)
        |=> (cmp_act_q[0] == $past(cmp_act_q[0])))
        else $error("buffered compare a changed before top");

endmodule
`default_nettype wire

//--- core/tw_params.svh
/*
 * Register offsets, field positions, reset values and divider counts of
 * the timer waveform output unit.
 * Assumes inclusion by bare name from the unit and its package users.
 */
// Behaviour
// R01: A nonzero output action drives the pin from the waveform state.
// R02: The direction bit alone decides whether the pin is driven.
// R03: Pin override depends only on the output action, never on the mode.
// R04: Output action zero leaves the waveform state unchanged on a match.
// R05: New action applies from the next match; force applies at once (the code ignores force in fast PWM).
// R06: Only the wave generation mode selects the counting sequence.
// R07: Mode 0 counts up forever and wraps from 0xFF to 0x00.
// R08: Normal mode sets overflow as the count becomes zero; never clears it.
// R09: In normal mode software may write the count at any time.
// R10: Mode 2 clears the count when it matches channel A compare.
// R11: Clear mode compare is unbuffered; a low value means wrapping first.
// R12: Clear mode with action 1 toggles channel A on each match.
// R13: Clear mode raises match A at TOP and overflow passing MAX.
// R14: Modes 0x3 and 0x7 are fast PWM; TOP is 0xFF or compare A.
// R15: Fast PWM counts up to TOP then clears on the next tick.
// R16: Fast PWM action 2 clears on match, sets at BOTTOM; 3 inverts.
// R17: Fast PWM sets overflow each time the count reaches TOP.
// R18: Compare BOTTOM gives a one-tick spike; MAX gives a steady level.
// R19: Fast PWM action 1 toggles on match with buffered compare.
// R20: Clear mode toggle period is 2 times N times compare plus one.
// R21: Fast PWM with TOP 0xFF repeats every 256 times N clocks.
// R22: A match sets its flag next tick; writing one clears it.
// R23: PWM compares are buffered to TOP; other modes write directly.
// R24: Force updates the waveform but sets no flag and keeps the count.
// R25: Other mode codes count as normal mode.
`ifndef TW_PARAMS_SVH
`define TW_PARAMS_SVH
`define TW_OFF_CTRL 8'h00
`define TW_OFF_FORCE 8'h04
`define TW_OFF_COUNT 8'h08
`define TW_OFF_CMPA 8'h0c
`define TW_OFF_CMPB 8'h10
`define TW_OFF_FLAGS 8'h14
`define TW_OFF_PORT 8'h18
`define TW_CTRL_LSB 0
`define TW_FLAG_OVF 0
`define TW_FLAG_MA 1
`define TW_PORT_OUT_LSB 0
`define TW_PORT_DIR_LSB 2
`define TW_CTRL_RST 11'h000
`define TW_FLAGS_RST 3'h0
`define TW_CMP_RST 8'h00
`define TW_PORT_RST 2'h0
`define TW_CNT_MAX 8'hff
`define TW_CNT_BOTTOM 8'h00
`define TW_WGM_CTC 3'h2
`define TW_WGM_FAST_MAX 3'h3
`define TW_WGM_FAST_TOP 3'h7
`define TW_DIV_1 1
`define TW_DIV_8 8
`define TW_DIV_32 32
`define TW_DIV_64 64
`define TW_DIV_128 128
`define TW_DIV_256 256
`define TW_DIV_1024 1024
`endif

//--- core/tw_pkg.sv
/*
 * Types shared by the timer waveform output unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package tw_pkg;
    typedef enum logic [1:0] {
        TW_NORMAL = 2'b00,
        TW_CLEAR = 2'b01,
        TW_FAST = 2'b10
    } tw_cnt_e;
    typedef enum logic [1:0] {
        TW_ACT_NONE = 2'b00,
        TW_ACT_TOGGLE = 2'b01,
        TW_ACT_CLEAR = 2'b10,
        TW_ACT_SET = 2'b11
    } tw_act_e;
    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic rsv;
        logic [2:0] wgm;
    } tw_ctrl_s;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
    } tw_ap_s;
endpackage
`default_nettype wire

//--- tb/tw_pin_load.sv
/*
 * Port pin load model: each pin carries a pull-up, so a pin that the
 * unit does not drive reads high.
 * Assumes one level and one drive enable per pin from the unit.
 */
`default_nettype none
module tw_pin_load (
    input wire logic i_drive,
    input wire logic i_oe,
    output logic o_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Undriven pins float up, so a stale level can never pass for a drive.
    assign o_level = i_oe ? i_drive : 1'b1;
endmodule
`default_nettype wire

//--- tb/tb_tw_unit.sv
/*
 * Self-checking bench of the timer waveform output unit: register tasks
 * over AHB-Lite, a table of waveform cases, then pin and flag checks.
 * Assumes the unit answers with zero wait states and a pull-up load.
 */
`include "tw_params.svh"
`default_nettype none
module tb_tw_unit;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] cmp;
        logic [31:0] hi;
        logic [31:0] per;
    } tw_row_s;
    tw_row_s rows [6] = '{
        '{32'h112, 32'h03, 32'd4, 32'd8},
        '{32'h212, 32'h03, 32'd32, 32'd64},
        '{32'h123, 32'h40, 32'd65, 32'd256},
        '{32'h133, 32'h40, 32'd191, 32'd256},
        '{32'h123, 32'h00, 32'd1, 32'd256},
        '{32'h117, 32'h09, 32'd10, 32'd20}
    };
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hresp;
    logic [31:0] c1;
    logic [31:0] c2;
    logic [31:0] hi;
    logic [31:0] per;
    wire logic hready;
    logic pa, pa_oe, pb, pb_oe, la, lb;
    int err_count = 0;
    int check_count = 0;
    int k;

    tw_unit dut (.i_ref_clk(clk), .i_rst(rst), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_pin_a(la), .o_pin_a(pa), .o_pin_a_oe(pa_oe),
        .i_pin_b(lb), .o_pin_b(pb), .o_pin_b_oe(pb_oe));
    tw_pin_load load_a (.i_drive(pa), .i_oe(pa_oe), .o_level(la));
    tw_pin_load load_b (.i_drive(pb), .i_oe(pb_oe), .o_level(lb));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic test_done();
        $display("mismatches %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic tick(inout int n);
        @(posedge clk);
        n++;
    endtask

    // Holds each phase until hready is sampled high; the data phase
    // answer is taken at that same edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do tick(n); while (hready !== 1'b1 && n < 16);
        htrans <= 2'b00;
        hwdata <= wd;
        do tick(n); while (hready !== 1'b1 && n < 32);
        rd = hrdata;
        if (n >= 32) err_count++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(nm, e, d);
    endtask

    // Pin drive lags the register by one clock, sync input by two more.
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    task automatic meas(output logic [31:0] h, output logic [31:0] p);
        int n;
        int s;
        n = 0;
        while (pa !== 1'b0 && n < 3000) tick(n);
        while (pa !== 1'b1 && n < 3000) tick(n);
        s = n;
        while (pa === 1'b1 && n < 3000) tick(n);
        h = n - s;
        while (pa !== 1'b1 && n < 3000) tick(n);
        p = n - s;
        if (n >= 3000) err_count++;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rc("ctrl", `TW_OFF_CTRL, 32'h0);
        rc("flags", `TW_OFF_FLAGS, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("oe", 32'h0, {31'h0, pa_oe});
        wr(8'h1c, 32'hff);
        rc("unmapped", 8'h1c, 32'h0);
        wr(`TW_OFF_PORT, 32'h01);
        settle();
        chk("pin", 32'h1, {30'h0, pa_oe, pa});
        rc("port", `TW_OFF_PORT, 32'hc1);
        wr(`TW_OFF_PORT, 32'h05);
        wr(`TW_OFF_CTRL, 32'h013);
        settle();
        chk("pin", 32'h2, {30'h0, pa_oe, pa});
        rc("port", `TW_OFF_PORT, 32'h85);
        wr(`TW_OFF_CTRL, 32'h010);
        settle();
        chk("pin", 32'h2, {30'h0, pa_oe, pa});
        wr(`TW_OFF_COUNT, 32'h55);
        wr(`TW_OFF_CTRL, 32'h030);
        wr(`TW_OFF_FORCE, 32'h1);
        settle();
        rc("port", `TW_OFF_PORT, 32'hd5);
        rc("count", `TW_OFF_COUNT, 32'h55);
        rc("flags", `TW_OFF_FLAGS, 32'h0);
        wr(`TW_OFF_CTRL, 32'h0);
        wr(`TW_OFF_FORCE, 32'h1);
        wr(`TW_OFF_CTRL, 32'h010);
        settle();
        chk("pin", 32'h3, {30'h0, pa_oe, pa});
        wr(`TW_OFF_FORCE, 32'h1);
        settle();
        chk("pin", 32'h2, {30'h0, pa_oe, pa});
        wr(`TW_OFF_CTRL, 32'h0c0);
        wr(`TW_OFF_FORCE, 32'h2);
        wr(`TW_OFF_PORT, 32'h0c);
        settle();
        chk("pin b", 32'h3, {30'h0, pb_oe, pb});
        wr(`TW_OFF_CMPA, 32'hff);
        wr(`TW_OFF_COUNT, 32'hfe);
        wr(`TW_OFF_FLAGS, 32'h7);
        wr(`TW_OFF_CTRL, 32'h100);
        bus(1'b0, `TW_OFF_COUNT, 32'h0, c1);
        bus(1'b0, `TW_OFF_COUNT, 32'h0, c2);
        chk("step", 32'h3, {24'h0, c2[7:0] - c1[7:0]});
        wr(`TW_OFF_CTRL, 32'h0);
        rc("flags", `TW_OFF_FLAGS, 32'h7);
        wr(`TW_OFF_FLAGS, 32'h7);
        rc("flags", `TW_OFF_FLAGS, 32'h0);
        wr(`TW_OFF_CTRL, 32'h002);
        wr(`TW_OFF_COUNT, 32'h10);
        wr(`TW_OFF_CMPA, 32'h03);
        wr(`TW_OFF_CTRL, 32'h102);
        repeat (100) @(posedge clk);
        bus(1'b0, `TW_OFF_COUNT, 32'h0, c1);
        chk("no clear", 32'h1, {31'h0, c1[7:0] > 8'h10});
        repeat (200) @(posedge clk);
        rc("flags", `TW_OFF_FLAGS, 32'h7);
        wr(`TW_OFF_PORT, 32'h04);
        foreach (rows[i]) begin
            wr(`TW_OFF_CTRL, rows[i].ctrl);
            wr(`TW_OFF_CMPA, rows[i].cmp);
            meas(hi, per);
            meas(hi, per);
            chk("high", rows[i].hi, hi);
            chk("period", rows[i].per, per);
        end
        for (int a = 2; a < 4; a++) begin
            wr(`TW_OFF_CTRL, 32'h103 | (a << 4));
            wr(`TW_OFF_CMPA, 32'hff);
            repeat (600) @(posedge clk);
            k = 0;
            repeat (300) begin
                @(posedge clk);
                if (pa === (a == 2)) k++;
            end
            chk("steady", 32'd300, k);
        end
        wr(`TW_OFF_FLAGS, 32'h7);
        repeat (300) @(posedge clk);
        rc("flags", `TW_OFF_FLAGS, 32'h7);
        // A reset in mid-run must stop the timer and release pin a.
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rc("ctrl", `TW_OFF_CTRL, 32'h0);
        rc("flags", `TW_OFF_FLAGS, 32'h0);
        chk("oe", 32'h0, {31'h0, pa_oe});
        test_done();
    end
endmodule
`default_nettype wire
